// ---- rtl/adc_cfg_defs.vh ----
// Constants for the converter configuration register block.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef ADC_CFG_DEFS_VH
`define ADC_CFG_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CONFIG 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_CLR 8'h0C
`define OFS_IRQ_EN 8'h10
`define OFS_MEAS 8'h14

// ****************************************************************
// Configuration field positions
// ****************************************************************
`define CFG_CHOP 23
`define CFG_ZERO19 19
`define CFG_PSEUDO 18
`define CFG_ZERO17 17
`define CFG_TEMP 16
`define CFG_CH_HI 15
`define CFG_CH_LO 8
`define CFG_BURN 7
`define CFG_REFERENCE_DETECT_ENABLE 6
`define CFG_ZERO5 5
`define CFG_BUF 4
`define CFG_UNIPOLAR 3

// Writable bits of the configuration word; bits 22, 21, 5 read zero.
`define CFG_WMASK 24'h9FFFDF
`define CFG_RESET 24'h000117

// ****************************************************************
// Status and timing
// ****************************************************************
`define CHD_TEMP 4'hF
`define SETTLE_NS 20000
`define CLK_NS 10
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- rtl/adc_config_channel_fields.v ----
// Configuration channel fields of the converter, with Wishbone registers.
// Assumes a classic Wishbone master, one clock, and asynchronous pin inputs
// for the reference comparator and the conversion sample data.
`include "adc_cfg_defs.vh"

module adc_config_channel_fields (
  input wire core_clk,
  input wire nrst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ref_low_pin,
  input wire [23:0] sample_pin,
  output reg [3:0] pos_input_sel,
  output reg neg_is_common,
  output reg [3:0] neg_input_sel,
  output reg temp_sensor_sel,
  output reg burnout_enable,
  output reg buffer_enable,
  output reg unipolar_coding,
  output reg result_valid,
  output reg irq
);

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  reg [23:0] cfg;
  reg [3:0] irq_stat;
  reg [3:0] irq_en;
  reg [23:0] result;
  reg [3:0] status_channel_indicator;
  reg missing_reference_flag;
  reg ref_low_s1;
  reg ref_low_s2;
  reg [23:0] sample_s1;
  reg [23:0] sample_s2;
  reg [3:0] chan_code;
  reg [3:0] held_code;
  reg sel_change;
  reg [3:0] next_irq_stat;
  reg [31:0] rd_data;
  reg [23:0] wdata;
  reg [23:0] new_cfg;
  wire settle_busy;
  wire settle_done;
  wire wr_stb;
  wire ref_rise;

  // Merges written bytes into a 24-bit register under the byte enables.
  function [23:0] merge24;
    input [23:0] old;
    input [31:0] dat;
    input [3:0] sel;
    begin
      merge24 = old;
      if (sel[0]) begin
        merge24[7:0] = dat[7:0];
      end
      if (sel[1]) begin
        merge24[15:8] = dat[15:8];
      end
      if (sel[2]) begin
        merge24[23:16] = dat[23:16];
      end
    end
  endfunction

  // Channel indicator code for a given configuration word.
  function [3:0] code_of;
    input [23:0] c;
    begin
      if (c[`CFG_TEMP]) begin
        code_of = `CHD_TEMP;
      end else begin
        code_of = c[`CFG_CH_HI:`CFG_CH_HI-3];
      end
    end
  endfunction

  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ref_low_s1 <= 1'b0;
      ref_low_s2 <= 1'b0;
      sample_s1 <= 24'h000000;
      sample_s2 <= 24'h000000;
    end else begin
      ref_low_s1 <= ref_low_pin;
      ref_low_s2 <= ref_low_s1;
      sample_s1 <= sample_pin;
      sample_s2 <= sample_s1;
    end
  end

  // ****************************************************************
  // Configuration write
  // ****************************************************************
  always @* begin
    wdata = merge24(cfg, wb_dat_i, wb_sel_i);
    new_cfg = wdata & `CFG_WMASK;
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= `CFG_RESET;
      irq_en <= 4'h0;
      sel_change <= 1'b0;
    end else begin
      sel_change <= 1'b0;
      if (wr_stb && wb_adr_i == `OFS_CONFIG) begin
        cfg <= new_cfg;
        if (new_cfg[`CFG_PSEUDO:`CFG_CH_LO] != cfg[`CFG_PSEUDO:`CFG_CH_LO]) begin
          sel_change <= 1'b1;
        end
      end
      if (wr_stb && wb_adr_i == `OFS_IRQ_EN && wb_sel_i[0]) begin
        irq_en <= wb_dat_i[3:0];
      end
    end
  end

  // ****************************************************************
  // Analog control outputs
  // ****************************************************************
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pos_input_sel <= 4'h0;
      neg_input_sel <= 4'h0;
      neg_is_common <= 1'b0;
      temp_sensor_sel <= 1'b0;
      burnout_enable <= 1'b0;
      buffer_enable <= 1'b0;
      unipolar_coding <= 1'b0;
    end else begin
      pos_input_sel <= cfg[`CFG_CH_HI:`CFG_CH_HI-3];
      neg_is_common <= cfg[`CFG_PSEUDO];
      if (cfg[`CFG_PSEUDO]) begin
        neg_input_sel <= 4'h0;
      end else begin
        neg_input_sel <= cfg[`CFG_CH_LO+3:`CFG_CH_LO];
      end
      temp_sensor_sel <= cfg[`CFG_TEMP];
      burnout_enable <= cfg[`CFG_BURN] & cfg[`CFG_BUF] & ~cfg[`CFG_CHOP];
      buffer_enable <= cfg[`CFG_BUF];
      unipolar_coding <= cfg[`CFG_UNIPOLAR];
    end
  end

  // ****************************************************************
  // Settling and result capture
  // ****************************************************************
  adc_settle_timer u_settle (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(sel_change),
    .busy(settle_busy),
    .done(settle_done)
  );

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      result <= 24'h000000;
      held_code <= 4'h0;
      result_valid <= 1'b0;
      chan_code <= 4'h0;
    end else begin
      chan_code <= code_of(cfg);
      result_valid <= 1'b0;
      if (settle_done && !sel_change) begin
        result <= sample_s2;
        held_code <= chan_code;
        result_valid <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Status
  // ****************************************************************
  assign ref_rise = ref_low_s2 & cfg[`CFG_REFERENCE_DETECT_ENABLE] & ~missing_reference_flag;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_channel_indicator <= 4'h0;
      missing_reference_flag <= 1'b0;
    end else begin
      status_channel_indicator <= held_code;
      missing_reference_flag <= ref_low_s2 & cfg[`CFG_REFERENCE_DETECT_ENABLE];
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  always @* begin
    next_irq_stat = irq_stat;
    if (wr_stb && wb_adr_i == `OFS_IRQ_CLR && wb_sel_i[0]) begin
      next_irq_stat = irq_stat & ~wb_dat_i[3:0];
    end
    next_irq_stat[0] = next_irq_stat[0] | (settle_done & ~sel_change);
    next_irq_stat[1] = next_irq_stat[1] | ref_rise;
    next_irq_stat[2] = next_irq_stat[2] | sel_change;
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_en);
    end
  end

  // ****************************************************************
  // Wishbone read and acknowledge
  // ****************************************************************
  always @* begin
    case (wb_adr_i)
      `OFS_CONFIG: rd_data = {8'h00, cfg};
      `OFS_STATUS: rd_data = {24'h000000, 1'b0, missing_reference_flag, settle_busy, 1'b0,
        status_channel_indicator};
      `OFS_IRQ_STAT: rd_data = {28'h0000000, irq_stat};
      `OFS_IRQ_EN: rd_data = {28'h0000000, irq_en};
      `OFS_MEAS: rd_data = {8'h00, result};
      default: rd_data = 32'h00000000;
    endcase
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule

// ---- rtl/adc_settle_timer.v ----
// Settling timer: counts a full filter settling period after each start.
// Assumes start is a one-cycle pulse from logic on the same clock.
`include "adc_cfg_defs.vh"

module adc_settle_timer (
  input wire core_clk,
  input wire nrst,
  input wire start,
  output reg busy,
  output reg done
);

  reg [11:0] count;

  // ****************************************************************
  // Counter
  // ****************************************************************
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= 12'h000;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      count <= 12'h000;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      if (count == (`SETTLE_CYC - 1)) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else begin
        count <= count + 12'h001;
        done <= 1'b0;
      end
    end else begin
      done <= 1'b0;
    end
  end

endmodule

// ---- sim/adc_cfg_props.sv ----
// Checker for the configuration channel block.
// Bound to the block; it watches the block's ports only.
module adc_cfg_props (
  input wire core_clk,
  input wire nrst,
  input wire wb_we_i,
  input wire wb_ack_o,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire [3:0] pos_input_sel,
  input wire [3:0] neg_input_sel,
  input wire neg_is_common,
  input wire temp_sensor_sel,
  input wire burnout_enable,
  input wire buffer_enable,
  input wire unipolar_coding,
  input wire result_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] since;
  // Counts cycles since the selected channel last changed.
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst) since <= 16'h0000;
    else if ($changed({pos_input_sel, neg_input_sel, neg_is_common, temp_sensor_sel}))
      since <= 16'h0000;
    else if (since != 16'hFFFF) since <= since + 16'h0001;
  sequence s_wr;
    wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[2:0] == 3'h7;
  endsequence
  property p_pos; s_wr |=> pos_input_sel == $past(wb_dat_i[15:12]); endproperty
  property p_com; s_wr |=> neg_is_common == $past(wb_dat_i[18]); endproperty
  property p_neg; neg_is_common |-> neg_input_sel == 4'h0; endproperty
  property p_tmp; s_wr |=> temp_sensor_sel == $past(wb_dat_i[16]); endproperty
  property p_brn;
    s_wr |=> burnout_enable == ($past(wb_dat_i[7]) & $past(wb_dat_i[4]) & ~$past(wb_dat_i[23]));
  endproperty
  property p_dif; s_wr ##0 !wb_dat_i[18] |=> neg_input_sel == $past(wb_dat_i[11:8]); endproperty
  property p_buf; s_wr |=> buffer_enable == $past(wb_dat_i[4]); endproperty
  property p_uni; s_wr |=> unipolar_coding == $past(wb_dat_i[3]); endproperty
  property p_set; result_valid |-> since > 16'h07CE; endproperty
  property p_rsv;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> (wb_dat_o & 32'h000A0020) == 32'h0;
  endproperty
  a_pos: assert property (p_pos) else $error("select bad");
  a_com: assert property (p_com) else $error("common bad");
  a_neg: assert property (p_neg) else $error("negative bad");
  a_dif: assert property (p_dif) else $error("differential negative bad");
  a_tmp: assert property (p_tmp) else $error("sensor bad");
  a_brn: assert property (p_brn) else $error("test current bad");
  a_buf: assert property (p_buf) else $error("buffer bad");
  a_uni: assert property (p_uni) else $error("coding bad");
  a_set: assert property (p_set) else $error("early result");
  a_rsv: assert property (p_rsv) else $error("zero bits set");
endmodule

bind adc_config_channel_fields adc_cfg_props chk (.*);

// ---- sim/adc_config_channel_fields_tb.sv ----
// Testbench for the configuration channel block.
// Assumes the checker is bound to the block from its own file.
module adc_config_channel_fields_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, nrst = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, ref_low_pin = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, pos_input_sel, neg_input_sel;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, w;
  logic [23:0] sample_pin = 24'h0;
  logic wb_ack_o, neg_is_common, temp_sensor_sel, burnout_enable, buffer_enable;
  logic unipolar_coding, result_valid, irq;
  logic [31:0] eq[$], mq[$];
  int bad_count = 0, checks_done = 0, cyc = 0, n;
  adc_config_channel_fields uut (.*);
  initial forever #5 core_clk = ~core_clk;
  task check(input string s, input logic [31:0] e, g);
    checks_done++;
    if (e !== g) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Classic single Wishbone cycle; a read notes its expected data.
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d, e, m);
    @(posedge core_clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    if (!we) begin
      eq.push_back(e);
      mq.push_back(m);
    end
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
  endtask
  task irq_step(input logic [7:0] a, input logic [31:0] d, input logic e);
    bus(1, a, d, 0, 0);
    repeat (2) @(posedge core_clk);
    check("irq", e, irq);
  endtask
  // Compares each read answer with the oldest note; also cuts a hang short.
  always @(posedge core_clk) begin
    if (nrst && wb_ack_o === 1'b1 && !wb_we_i && eq.size() > 0) begin
      check("read data", eq[0] & mq[0], wb_dat_o & mq[0]);
      eq.pop_front();
      mq.pop_front();
    end
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'h0812));
    repeat (6) @(posedge core_clk);
    nrst <= 1;
    bus(0, 8'h00, 0, 32'h00000117, 32'hFFFFFFFF);
    bus(1, 8'h20, 32'hFFFFFFFF, 0, 0);
    bus(0, 8'h20, 0, 0, 32'hFFFFFFFF);
    bus(1, 8'h10, 1, 0, 0);
    for (int k = 0; k < 4; k++) begin
      w = $urandom;
      w[15:12] = k + 1;
      w[16] = k == 2;
      w[18] = k[0];
      w[6] = k[1];
      w[19] = 1'b0;
      w[17] = 1'b0;
      w[5] = 1'b0;
      ref_low_pin <= k[0];
      sample_pin <= $urandom;
      bus(1, 8'h00, w, 0, 0);
      n = 0;
      while (result_valid !== 1'b1 && n < 3000) begin
        @(posedge core_clk);
        n++;
      end
      check("settle", 1, n > 1999 && n < 2006);
      bus(0, 8'h00, 0, w & 32'h009FFFDF, 32'hFFFFFFFF);
      bus(0, 8'h04, 0, {w[6] & k[0], 2'b00, k == 2 ? 4'hF : w[15:12]}, 32'h7F);
      bus(0, 8'h08, 0, {1'b1, k == 3, 1'b1}, 32'hF);
      bus(0, 8'h14, 0, sample_pin, 32'hFFFFFF);
      check("irq", 1, irq);
      irq_step(8'h10, 0, 0);
      irq_step(8'h10, 1, 1);
      irq_step(8'h0C, 1, 0);
    end
    // A reset in mid-run brings the configuration back to its reset value.
    nrst <= 0;
    repeat (2) @(posedge core_clk);
    nrst <= 1;
    check("irq after reset", 0, irq);
    bus(0, 8'h00, 0, 32'h00000117, 32'hFFFFFFFF);
    bus(0, 8'h08, 0, 0, 32'hF);
    end_sim();
  end
endmodule
